// ==== verilog/flash_cfg_pkg.sv ====
package flash_cfg_pkg;
   // register byte addresses on the bus
   localparam logic [7:0] ADDR_PIN_DRIVE = 8'h00;
   localparam logic [7:0] ADDR_POWER_PROG = 8'h04;
   localparam logic [7:0] ADDR_COMMAND = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_LOCKS = 8'h10;
   // pin_drive_protect_config fields
   localparam int PIN_FUNC_BIT = 7;
   localparam int DRIVE_HI = 6;
   localparam int DRIVE_LO = 5;
   localparam int SCHEME_BIT = 2;
   localparam logic [7:0] PIN_DRIVE_WMASK = 8'hE4;
   localparam logic [7:0] PIN_DRIVE_RESET = 8'h20;
   // power_program_mode_config fields
   localparam int PDM_BIT = 7;
   localparam int SPM_BIT = 6;
   // drive level codes
   localparam logic [1:0] DRIVE_RSVD = 2'h0;
   localparam logic [1:0] DRIVE_FULL = 2'h1;
   localparam logic [1:0] DRIVE_TWO_THIRDS = 2'h2;
   localparam logic [1:0] DRIVE_ONE_THIRD = 2'h3;
   // command codes
   localparam logic [7:0] CMD_BLOCK_LOCK = 8'h36;
   localparam logic [7:0] CMD_BLOCK_UNLOCK = 8'h39;
   localparam logic [7:0] CMD_POWER_DOWN = 8'hB9;
   localparam logic [7:0] CMD_ULTRA_DEEP = 8'h79;
   localparam logic [7:0] CMD_WAKE = 8'hAB;
   // command register fields
   localparam int CMD_BLOCK_LSB = 8;
   localparam int CMD_CS_BIT = 16;
   localparam int CMD_SEQ_START_BIT = 17;
   localparam int CMD_SEQ_STOP_BIT = 18;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {PWR_ACTIVE, PWR_DEEP, PWR_ULTRA} power_state_e;
endpackage : flash_cfg_pkg

// ==== verilog/block_lock_bank.sv ====
`timescale 1ns/1ps
module block_lock_bank
   import flash_cfg_pkg::*;
#(
   parameter int BLOCKS = 16,
   parameter int IDX_W = 4
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic lock_pulse,
   input wire logic unlock_pulse,
   input wire logic [IDX_W-1:0] block_index,
   output logic [BLOCKS-1:0] locks
);
   genvar g;
   generate
      for (g = 0; g < BLOCKS; g++) begin : g_lock
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               locks[g] <= 1'b1;
            end else if (block_index == IDX_W'(g)) begin
               if (lock_pulse) begin
                  locks[g] <= 1'b1;
               end else if (unlock_pulse) begin
                  locks[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate
endmodule : block_lock_bank

// ==== verilog/flash_config_status_regs.sv ====
`timescale 1ns/1ps
module flash_config_status_regs
   import flash_cfg_pkg::*;
#(
   parameter int BLOCKS = 16,
   parameter int IDX_W = 4,
   parameter int ADDR_W = 24
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic quad_enable,
   input wire logic hold_reset_pin_n,
   input wire logic [5:0] region_protect,
   input wire logic [IDX_W-1:0] target_block,
   input wire logic seq_addr_step,
   output logic hold_active_reg,
   output logic pin_reset_reg,
   output logic [1:0] drive_level_reg,
   output logic [1:0] drive_strength_reg,
   output logic region_enable_reg,
   output logic target_locked_reg,
   output logic [1:0] power_state_reg,
   output logic sram_keep_reg,
   output logic [ADDR_W-1:0] seq_addr_reg
);
   logic [7:0] cfg_pin_reg;
   logic power_down_depth_select;
   logic sequential_program_flag;
   power_state_e pstate_reg;
   logic [BLOCKS-1:0] locks;
   logic aw_full_reg, w_full_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_go;
   logic lock_pulse, unlock_pulse;
   logic [7:0] cmd_code;
   logic [2:0] pin_sync_reg;
   logic pin_level_reg;
   logic cs_seen_reg;
   logic [31:0] rd_value;
   logic rd_hit;

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == ADDR_PIN_DRIVE) || (a == ADDR_POWER_PROG) || (a == ADDR_COMMAND)
         || (a == ADDR_STATUS) || (a == ADDR_LOCKS);
   endfunction : reg_hit

   // write channel capture, address and data in either order
   assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (wr_go) begin
         aw_full_reg <= 1'b0;
      end else if (!aw_full_reg && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (wr_go) begin
         w_full_reg <= 1'b0;
      end else if (!w_full_reg && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= reg_hit(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // pin config register, reserved bits masked off
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg_pin_reg <= PIN_DRIVE_RESET;
      end else if (wr_go && aw_addr_reg == ADDR_PIN_DRIVE && w_strb_reg[0]) begin
         cfg_pin_reg <= w_data_reg[7:0] & PIN_DRIVE_WMASK;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         power_down_depth_select <= 1'b0;
      end else if (wr_go && aw_addr_reg == ADDR_POWER_PROG && w_strb_reg[0]) begin
         power_down_depth_select <= w_data_reg[PDM_BIT];
      end
   end

   // command register: a write with byte 0 strobed issues one command in the same cycle
   assign cmd_code = w_data_reg[7:0];
   logic cmd_go;
   assign cmd_go = wr_go && aw_addr_reg == ADDR_COMMAND && w_strb_reg[0];
   // lock and unlock commands honoured only with lock scheme, awake
   assign lock_pulse = cmd_go && cfg_pin_reg[SCHEME_BIT] && pstate_reg == PWR_ACTIVE
      && cmd_code == CMD_BLOCK_LOCK;
   assign unlock_pulse = cmd_go && cfg_pin_reg[SCHEME_BIT] && pstate_reg == PWR_ACTIVE
      && cmd_code == CMD_BLOCK_UNLOCK;

   block_lock_bank #(.BLOCKS(BLOCKS), .IDX_W(IDX_W)) u_locks (
      .clk_sys(clk_sys),
      .reset(reset),
      .lock_pulse(lock_pulse),
      .unlock_pulse(unlock_pulse),
      .block_index(w_data_reg[CMD_BLOCK_LSB +: IDX_W]),
      .locks(locks)
   );

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pstate_reg <= PWR_ACTIVE;
      end else if (cmd_go) begin
         case (pstate_reg)
            PWR_ACTIVE: begin
               if (cmd_code == CMD_ULTRA_DEEP
                  || (cmd_code == CMD_POWER_DOWN && !power_down_depth_select)) begin
                  pstate_reg <= PWR_ULTRA;
               end else if (cmd_code == CMD_POWER_DOWN) begin
                  pstate_reg <= PWR_DEEP;
               end
            end
            PWR_DEEP, PWR_ULTRA: begin
               if (cmd_code == CMD_WAKE) begin
                  pstate_reg <= PWR_ACTIVE;
               end
            end
            default: pstate_reg <= PWR_ACTIVE;
         endcase
      end
   end

   // chip-select-only toggle is recorded but never wakes
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cs_seen_reg <= 1'b0;
      end else if (wr_go && aw_addr_reg == ADDR_COMMAND && w_strb_reg[2]) begin
         cs_seen_reg <= w_data_reg[CMD_CS_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sequential_program_flag <= 1'b0;
      end else if (cmd_go && pstate_reg == PWR_ACTIVE) begin
         if (w_data_reg[CMD_SEQ_STOP_BIT]) begin
            sequential_program_flag <= 1'b0;
         end else if (w_data_reg[CMD_SEQ_START_BIT]) begin
            sequential_program_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         seq_addr_reg <= '0;
      end else if (sequential_program_flag && seq_addr_step) begin
         seq_addr_reg <= seq_addr_reg + ADDR_W'(1);
      end else if (!sequential_program_flag) begin
         seq_addr_reg <= '0;
      end
   end

   // pin is asynchronous: three stages, change taken when the last two agree
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pin_sync_reg <= 3'h7;
         pin_level_reg <= 1'b1;
      end else begin
         pin_sync_reg <= {pin_sync_reg[1:0], hold_reset_pin_n};
         if (pin_sync_reg[2] == pin_sync_reg[1]) begin
            pin_level_reg <= pin_sync_reg[1];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hold_active_reg <= 1'b0;
         pin_reset_reg <= 1'b0;
      end else begin
         hold_active_reg <= !quad_enable && !cfg_pin_reg[PIN_FUNC_BIT] && !pin_level_reg;
         pin_reset_reg <= !quad_enable && cfg_pin_reg[PIN_FUNC_BIT] && !pin_level_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         drive_level_reg <= DRIVE_FULL;
         drive_strength_reg <= DRIVE_FULL;
      end else begin
         drive_level_reg <= cfg_pin_reg[DRIVE_HI:DRIVE_LO];
         // reserved code falls back to full strength
         case (cfg_pin_reg[DRIVE_HI:DRIVE_LO])
            DRIVE_FULL: drive_strength_reg <= DRIVE_FULL;
            DRIVE_TWO_THIRDS: drive_strength_reg <= DRIVE_TWO_THIRDS;
            DRIVE_ONE_THIRD: drive_strength_reg <= DRIVE_ONE_THIRD;
            default: drive_strength_reg <= DRIVE_FULL;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         region_enable_reg <= 1'b0;
         target_locked_reg <= 1'b1;
      end else begin
         region_enable_reg <= !cfg_pin_reg[SCHEME_BIT] && (region_protect[2:0] != 3'h0);
         target_locked_reg <= cfg_pin_reg[SCHEME_BIT] && locks[target_block];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         power_state_reg <= 2'h0;
         sram_keep_reg <= 1'b1;
      end else begin
         power_state_reg <= pstate_reg;
         sram_keep_reg <= pstate_reg != PWR_ULTRA;
      end
   end

   // read channel, one cycle to answer
   always_comb begin
      rd_hit = reg_hit(s_axi_araddr);
      case (s_axi_araddr)
         ADDR_PIN_DRIVE: rd_value = {24'h000000, cfg_pin_reg};
         ADDR_POWER_PROG: rd_value = {24'h000000, power_down_depth_select,
            sequential_program_flag, 6'h00};
         ADDR_STATUS: rd_value = {28'h0000000, cs_seen_reg, 1'b0, pstate_reg};
         ADDR_LOCKS: rd_value = 32'(locks);
         default: rd_value = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
         s_axi_arready <= 1'b1;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_value;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (reset)
      (cfg_pin_reg & ~PIN_DRIVE_WMASK) == 8'h00) else $error("reserved bits set");
   AST_PIN_FUNC: assert property (@(posedge clk_sys) disable iff (reset)
      pin_reset_reg |-> $past(cfg_pin_reg[PIN_FUNC_BIT])) else $error("reset func wrong");
   AST_QUAD_OFF: assert property (@(posedge clk_sys) disable iff (reset)
      $past(quad_enable) |-> !hold_active_reg && !pin_reset_reg) else $error("quad ignored");
   AST_DRIVE: assert property (@(posedge clk_sys) disable iff (reset)
      $past(cfg_pin_reg[DRIVE_HI:DRIVE_LO]) == DRIVE_ONE_THIRD
      |-> drive_strength_reg == DRIVE_ONE_THIRD) else $error("drive decode");
   AST_REGION: assert property (@(posedge clk_sys) disable iff (reset)
      region_enable_reg |-> !$past(cfg_pin_reg[SCHEME_BIT])) else $error("region on");
   AST_BLOCK: assert property (@(posedge clk_sys) disable iff (reset)
      target_locked_reg |-> $past(locks[target_block])) else $error("lock scheme");
   AST_LOCK_RESET: assert property (@(posedge clk_sys)
      $fell(reset) |-> &locks) else $error("locks not set");
   AST_LOCK_CMD: assert property (@(posedge clk_sys) disable iff (reset)
      unlock_pulse |=> !locks[$past(w_data_reg[CMD_BLOCK_LSB +: IDX_W])])
      else $error("unlock failed");
   AST_ULTRA: assert property (@(posedge clk_sys) disable iff (reset)
      cmd_go && pstate_reg == PWR_ACTIVE && cmd_code == CMD_POWER_DOWN
      && !power_down_depth_select |=> pstate_reg == PWR_ULTRA ##1 !sram_keep_reg)
      else $error("ultra entry");
   AST_DEEP: assert property (@(posedge clk_sys) disable iff (reset)
      cmd_go && pstate_reg == PWR_ACTIVE && cmd_code == CMD_POWER_DOWN
      && power_down_depth_select |=> pstate_reg == PWR_DEEP) else $error("deep entry");
   AST_WAKE: assert property (@(posedge clk_sys) disable iff (reset)
      pstate_reg != PWR_ACTIVE && !(cmd_go && cmd_code == CMD_WAKE)
      |=> pstate_reg != PWR_ACTIVE) else $error("woke without wake");
   AST_SPM_READ: assert property (@(posedge clk_sys) disable iff (reset)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_POWER_PROG
      |=> s_axi_rdata[SPM_BIT] == $past(sequential_program_flag)) else $error("spm read");
endmodule : flash_config_status_regs

// ==== verif/flash_host_model.sv ====
`timescale 1ns/1ps
module flash_host_model (
   input wire logic clk_sys,
   output logic quad_enable,
   output logic hold_reset_pin_n,
   output logic [5:0] region_protect,
   output logic [3:0] target_block,
   output logic seq_addr_step
);
   initial begin
      quad_enable = 1'b0;
      hold_reset_pin_n = 1'b1;
      region_protect = 6'h00;
      target_block = 4'h0;
      seq_addr_step = 1'b0;
   end
   task automatic set_pins(input logic q, input logic p);
      quad_enable <= q;
      hold_reset_pin_n <= p;
   endtask : set_pins
   task automatic set_prot(input logic [5:0] rp, input logic [3:0] blk);
      region_protect <= rp;
      target_block <= blk;
   endtask : set_prot
   task automatic step(input int n);
      repeat (n) begin
         seq_addr_step <= 1'b1;
         @(posedge clk_sys);
         seq_addr_step <= 1'b0;
         @(posedge clk_sys);
      end
   endtask : step
endmodule : flash_host_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
   import flash_cfg_pkg::*;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_s;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic quad_enable, hold_reset_pin_n, seq_addr_step;
   logic [5:0] region_protect;
   logic [3:0] target_block;
   logic hold_active_reg, pin_reset_reg, region_enable_reg, target_locked_reg, sram_keep_reg;
   logic [1:0] drive_level_reg, drive_strength_reg, power_state_reg;
   logic [23:0] seq_addr_reg;
   exp_s rq[$];
   exp_s re;
   logic [1:0] bq[$];
   logic [15:0] locks_exp = 16'hFFFF;
   logic [5:0] rp;
   logic [3:0] blk;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;

   flash_config_status_regs #(.BLOCKS(16), .IDX_W(4), .ADDR_W(24)) flash_config_status_regs_inst (
      .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .quad_enable, .hold_reset_pin_n, .region_protect, .target_block,
      .seq_addr_step, .hold_active_reg, .pin_reset_reg, .drive_level_reg, .drive_strength_reg,
      .region_enable_reg, .target_locked_reg, .power_state_reg, .sram_keep_reg, .seq_addr_reg);
   flash_host_model flash_host_model_inst (.clk_sys, .quad_enable, .hold_reset_pin_n,
      .region_protect, .target_block, .seq_addr_step);

   initial begin
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict
   task automatic end_test(input string n);
      $display("test %s done", n);
   endtask : end_test
   // each channel is released at its own handshake; bready stays up until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bit aw;
      bit w;
      aw = 1'b1;
      w = 1'b1;
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
         input logic [1:0] r);
      bit ar;
      ar = 1'b1;
      rq.push_back('{d: d, m: m, r: r});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (ar && s_axi_arready) begin
            ar = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask : rd

   always @(posedge clk_sys) begin
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
         re = rq.pop_front();
         check("rdata", s_axi_rdata & re.m, re.d);
         check("rresp", 32'(s_axi_rresp), 32'(re.r));
      end
      if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
         check("bresp", 32'(s_axi_bresp), 32'(bq.pop_front()));
      end
   end

   // the whole run needs a few hundred cycles; the ceiling leaves ample margin
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      void'($urandom(1));
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      rd(ADDR_PIN_DRIVE, 32'h20, 32'hFF, RESP_OKAY);
      rd(ADDR_POWER_PROG, 32'h0, 32'hFF, RESP_OKAY);
      rd(ADDR_LOCKS, 32'hFFFF, 32'hFFFF, RESP_OKAY);
      rd(8'h14, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
      wr(8'h14, 32'h0, RESP_SLVERR);
      end_test("reset_values");
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_PIN_DRIVE, 32'h9B | (32'(c) << 5), RESP_OKAY);
         rd(ADDR_PIN_DRIVE, 32'h80 | (32'(c) << 5), 32'hFF, RESP_OKAY);
         check("drive_strength", 32'(drive_strength_reg), (c == 0) ? 32'h1 : 32'(c));
         check("drive_level", 32'(drive_level_reg), 32'(c));
      end
      end_test("drive_level");
      for (int i = 7; i >= 0; i--) begin
         wr(ADDR_PIN_DRIVE, {24'h0, i[1], 7'h20}, RESP_OKAY);
         flash_host_model_inst.set_pins(i[2], i[0]);
         // pin passes a three-flop synchroniser
         repeat (6) @(posedge clk_sys);
         check("hold", 32'(hold_active_reg), 32'(!i[2] && !i[1] && !i[0]));
         check("pin_reset", 32'(pin_reset_reg), 32'(!i[2] && i[1] && !i[0]));
      end
      flash_host_model_inst.set_pins(1'b0, 1'b1);
      end_test("pin_function");
      for (int s = 0; s < 2; s++) begin
         rp = 6'($urandom);
         blk = 4'($urandom);
         flash_host_model_inst.set_prot(rp, blk);
         wr(ADDR_PIN_DRIVE, 32'h20 | (32'(s) << 2), RESP_OKAY);
         wr(ADDR_COMMAND, {16'h0, 4'h0, blk, CMD_BLOCK_UNLOCK}, RESP_OKAY);
         if (s == 1) begin
            locks_exp[blk] = 1'b0;
         end
         repeat (3) @(posedge clk_sys);
         check("region", 32'(region_enable_reg), 32'(s == 0 && rp[2:0] != 3'h0));
         check("target_locked", 32'(target_locked_reg), 32'(s == 1 && locks_exp[blk]));
         rd(ADDR_LOCKS, 32'(locks_exp), 32'hFFFF, RESP_OKAY);
      end
      wr(ADDR_COMMAND, {16'h0, 4'h0, blk, CMD_BLOCK_LOCK}, RESP_OKAY);
      rd(ADDR_LOCKS, 32'hFFFF, 32'hFFFF, RESP_OKAY);
      check("target_locked", 32'(target_locked_reg), 32'h1);
      end_test("protection");
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_POWER_PROG, (k == 1) ? 32'h80 : 32'h0, RESP_OKAY);
         wr(ADDR_COMMAND, {24'h0, (k == 2) ? CMD_ULTRA_DEEP : CMD_POWER_DOWN}, RESP_OKAY);
         wr(ADDR_COMMAND, 32'h10000, RESP_OKAY);
         repeat (3) @(posedge clk_sys);
         check("power_state", 32'(power_state_reg), (k == 1) ? 32'h1 : 32'h2);
         check("sram_keep", 32'(sram_keep_reg), 32'(k == 1));
         rd(ADDR_STATUS, (k == 1) ? 32'h9 : 32'hA, 32'hF, RESP_OKAY);
         wr(ADDR_COMMAND, {24'h0, CMD_WAKE}, RESP_OKAY);
         repeat (3) @(posedge clk_sys);
         rd(ADDR_STATUS, 32'h0, 32'h3, RESP_OKAY);
      end
      end_test("power_down");
      wr(ADDR_POWER_PROG, 32'hC0, RESP_OKAY);
      rd(ADDR_POWER_PROG, 32'h80, 32'hFF, RESP_OKAY);
      wr(ADDR_COMMAND, 32'h20000, RESP_OKAY);
      rd(ADDR_POWER_PROG, 32'hC0, 32'hFF, RESP_OKAY);
      flash_host_model_inst.step(3);
      check("seq_addr_moves", 32'(seq_addr_reg), 32'h3);
      wr(ADDR_COMMAND, 32'h40000, RESP_OKAY);
      rd(ADDR_POWER_PROG, 32'h80, 32'hFF, RESP_OKAY);
      check("seq_addr_clear", 32'(seq_addr_reg), 32'h0);
      end_test("sequential");
      wr(ADDR_COMMAND, {16'h0, 4'h0, blk, CMD_BLOCK_UNLOCK}, RESP_OKAY);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      rd(ADDR_LOCKS, 32'hFFFF, 32'hFFFF, RESP_OKAY);
      rd(ADDR_PIN_DRIVE, 32'h20, 32'hFF, RESP_OKAY);
      rd(ADDR_POWER_PROG, 32'h0, 32'hFF, RESP_OKAY);
      end_test("mid_run_reset");
      give_verdict();
   end
endmodule : tb
